//--- tb/dpab_capture.sv
// model of the downstream logic that captures converted word pairs
`timescale 1ns/1ps
module dpab_capture (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic stall, // bench asks the capture side to hold off
  input wire logic out_valid, // pair on the bus is valid
  output logic out_ready, // model can take a pair
  output int taken // pairs accepted so far
);
  // ready follows the stall request, which the bench changes only at a falling edge
  assign out_ready = ~stall;
  // only valid pairs are taken, so power-up words never reach the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      taken <= 0;
    end else if (out_valid && out_ready) begin
      taken <= taken + 1;
    end
  end
endmodule // dpab_capture

//--- tb/tb_top.sv
// self-checking testbench for the dual pipeline converter back end
`timescale 1ns/1ps
module tb_top import dpab_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic [17:0] i_bits = '0;
  logic [17:0] q_bits = '0;
  logic [9:0] i_out, q_out;
  logic out_valid, out_ready, ph1, ph2;
  logic [8:0] sclk;
  logic [3:0] p1h = '0;
  logic [10:0] samp [0:511];
  bit chk_en = 1'b0;
  int mismatches = 0, num_checks = 0, cyc = 0, timer = 0, taken;

  dpab_backend i_dut (.clk(clk), .rst_n(rst_n), .i_stage_bits(i_bits), .q_stage_bits(q_bits),
    .out_ready(out_ready), .i_chan_out(i_out), .q_chan_out(q_out), .out_valid(out_valid),
    .phase1_reg_o(ph1), .phase2_reg_o(ph2), .stage_clk_o(sclk));
  dpab_capture i_cap (.clk(clk), .rst_n(rst_n), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .taken(taken));

  always #10 clk = ~clk;

  // bit 10 of a sample forces every stage word to 3, which must saturate
  function automatic logic [10:0] smp(int n);
    return (n < 0 || n > 511) ? 11'h000 : samp[n];
  endfunction
  function automatic logic [9:0] code(logic [10:0] s, bit inv);
    return s[10] ? 10'h3ff : (inv ? ~s[9:0] : s[9:0]);
  endfunction
  // stage k carries its sample k-1 cycles late, stage 1 in the top bits
  function automatic logic [17:0] bits(int c, bit inv);
    logic [17:0] b;
    logic [9:0] v;
    logic [10:0] s;
    b = '0;
    for (int k = 1; k <= 9; k++) begin
      s = smp(c - k + 1);
      v = code(s, inv);
      b[19-2*k -: 2] = s[10] ? 2'h3 : (k == 1 ? v[9:8] : {1'b0, v[9-k]});
    end
    return b;
  endfunction

  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // cycle count and hang guard; the run needs a few hundred cycles at most
  always @(posedge clk) begin
    cyc <= cyc + 1;
    timer <= timer + 1;
    if (timer == 3000) begin
      mismatches++;
      final_report;
    end
  end

  // stage words go out at the falling edge; outputs are judged there once settled
  always @(negedge clk) begin
    i_bits <= bits(cyc, 1'b0);
    q_bits <= bits(cyc, 1'b1);
    p1h <= {p1h[2:0], ph1};
    if (chk_en && out_valid === 1'b1) begin
      check("i word", i_out, code(smp(cyc - 12), 1'b0));
      check("q word", q_out, code(smp(cyc - 12), 1'b1));
    end
    if (chk_en) begin
      check("phase overlap", {9'h000, ph1 & ph2}, 10'h000);
      check("phase period", {9'h000, ph1}, {9'h000, p1h[3]});
      check("phase two", {9'h000, ph2}, {9'h000, p1h[1]});
      for (int s = 0; s < 9; s++) check("stage clock", {9'h000, sclk[s]}, {9'h000, ph1 ^ s[0]});
    end
  end

  // nothing valid for twenty cycles, then the stream starts within a bound
  task automatic warmup_scn;
    repeat (20) begin
      @(negedge clk);
      check("early valid", {9'h000, out_valid}, 10'h000);
    end
    for (int t = 0; t < 20 && out_valid !== 1'b1; t++) @(negedge clk);
    check("valid after warmup", {9'h000, out_valid}, 10'h001);
    chk_en = 1'b1;
  endtask

  // code table corners plus a saturating sample, sent back to back
  task automatic codes_scn;
    logic [10:0] tbl [7] = '{11'h3ff, 11'h3fe, 11'h200, 11'h1ff, 11'h001, 11'h000, 11'h400};
    for (int j = 0; j < 7; j++) samp[cyc + 2 + j] = tbl[j];
    repeat (24) @(negedge clk);
  endtask

  // a stalled sink must see the pair stand, then one pair per clock again
  task automatic stall_scn;
    int t0;
    logic [9:0] held_i, held_q;
    for (int n = cyc + 2; n < cyc + 60; n++) samp[n] = {1'b0, 10'(n)};
    repeat (16) @(negedge clk);
    chk_en = 1'b0;
    stall = 1'b1;
    held_i = i_out;
    held_q = q_out;
    repeat (4) begin
      @(negedge clk);
      check("held i word", i_out, held_i);
      check("held q word", q_out, held_q);
      check("held valid", {9'h000, out_valid}, 10'h001);
    end
    stall = 1'b0;
    t0 = taken;
    repeat (5) @(negedge clk);
    check("pairs taken", 10'(taken - t0), 10'h005);
  endtask

  // a reset in mid-stream clears valid and the i word and replays the power-up window
  task automatic reset_scn;
    rst_n = 1'b0;
    repeat (2) begin
      @(negedge clk);
      check("reset valid", {9'h000, out_valid}, 10'h000);
      check("reset i word", i_out, 10'h000);
    end
    rst_n = 1'b1;
    warmup_scn;
    repeat (8) @(negedge clk);
  endtask

  initial begin
    for (int n = 0; n < 512; n++) samp[n] = 11'h000;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    warmup_scn;
    codes_scn;
    stall_scn;
    reset_scn;
    final_report;
  end
endmodule // tb_top

//--- verilog/dpab_backend.sv
// dual channel pipeline adc digital back end: alignment, correction, output
`timescale 1ns/1ps
module dpab_backend import dpab_pkg::*; #(
  parameter int OUT_W = DPAB_OUT_W,
  parameter int STAGES = DPAB_STAGES,
  parameter int INVALID_CYC = DPAB_INVALID_CYC
) (
  input wire logic clk, // master sampling clock, 50 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [2*STAGES-1:0] i_stage_bits, // channel i stage words, stage 1 in top bits
  input wire logic [2*STAGES-1:0] q_stage_bits, // channel q stage words, stage 1 in top bits
  input wire logic out_ready, // capturing logic can take a word pair
  output logic [OUT_W-1:0] i_chan_out, // channel i result, offset binary, bit 9 is chan_out_msb
  output logic [OUT_W-1:0] q_chan_out, // channel q result, offset binary
  output logic out_valid, // result pair on the outputs is valid
  output logic phase1_reg_o, // internal track phase
  output logic phase2_reg_o, // internal hold phase
  output logic [STAGES-1:0] stage_clk_o // per-stage clocks, alternating
);
  localparam int RW = 2 * STAGES;

  // delay line: stage k output arrives k cycles late, so tap STAGES-1-k delays stage k by STAGES-k
  logic [RW-1:0] i_dl_reg [STAGES], i_dl_next [STAGES];
  logic [RW-1:0] q_dl_reg [STAGES], q_dl_next [STAGES];
  logic [RW-1:0] i_aligned, q_aligned;

  // correction: overlap-add of two-bit stage words, shifted one bit per stage
  function automatic logic [OUT_W-1:0] dpab_correct(input logic [RW-1:0] w);
    logic [OUT_W:0] acc;
    acc = '0;
    for (int k = 0; k < STAGES; k++) begin
      acc = acc + ((OUT_W+1)'(w[RW-1-2*k -: 2]) << (STAGES-1-k));
    end
    // saturate so overrange stays at full scale codes
    dpab_correct = acc[OUT_W] ? {OUT_W{1'b1}} : acc[OUT_W-1:0];
  endfunction

  // shift each stage word down a chain of registers
  // tap 0 is loaded apart so no constant index ever points below the array
  always_comb begin
    i_dl_next[0] = i_stage_bits;
    q_dl_next[0] = q_stage_bits;
    for (int s = 1; s < STAGES; s++) begin
      i_dl_next[s] = i_dl_reg[s-1];
      q_dl_next[s] = q_dl_reg[s-1];
    end
  end

  always_ff @(posedge clk) begin
    for (int s = 0; s < STAGES; s++) begin
      i_dl_reg[s] <= i_dl_next[s];
      q_dl_reg[s] <= q_dl_next[s];
    end
  end

  // pick each stage pair from its delay tap so all nine line up
  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_align
      assign i_aligned[RW-1-2*g -: 2] = i_dl_reg[STAGES-1-g][RW-1-2*g -: 2];
      assign q_aligned[RW-1-2*g -: 2] = q_dl_reg[STAGES-1-g][RW-1-2*g -: 2];
    end
  endgenerate

  // correction stage register, both channels identical
  logic [OUT_W-1:0] i_cor_reg, i_cor_next, q_cor_reg, q_cor_next;
  always_comb begin
    i_cor_next = dpab_correct(i_aligned);
    q_cor_next = dpab_correct(q_aligned);
  end
  always_ff @(posedge clk) begin
    i_cor_reg <= i_cor_next;
    q_cor_reg <= q_cor_next;
  end

  // two-phase non-overlapping clock model: phase1 track, gap, phase2 hold
  logic [1:0] ph_reg, ph_next;
  logic phase1_next, phase2_next;
  logic [STAGES-1:0] sclk_next;
  always_comb begin
    ph_next = ph_reg + 2'h1;
    phase1_next = (ph_reg == 2'h0);
    phase2_next = (ph_reg == 2'h2);
    for (int s = 0; s < STAGES; s++) begin
      sclk_next[s] = phase1_next ^ s[0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_reg <= 2'h0;
      phase1_reg_o <= 1'b0;
      phase2_reg_o <= 1'b0;
      stage_clk_o <= STAGES'(DPAB_SCLK_RST);
    end else begin
      ph_reg <= ph_next;
      phase1_reg_o <= phase1_next;
      phase2_reg_o <= phase2_next;
      stage_clk_o <= sclk_next;
    end
  end

  // power-up invalid window: count clocks, then let data through
  dpab_state_t st_reg, st_next;
  logic [4:0] wcnt_reg, wcnt_next;
  always_comb begin
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    case (st_reg)
      DPAB_WARMUP: begin
        wcnt_next = wcnt_reg + 5'h01;
        if (wcnt_reg == 5'(INVALID_CYC - 1)) begin
          st_next = DPAB_RUN;
        end
      end
      DPAB_RUN: wcnt_next = wcnt_reg;
      default: st_next = DPAB_WARMUP;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= DPAB_WARMUP;
      wcnt_reg <= DPAB_CNT_RST;
    end else begin
      st_reg <= st_next;
      wcnt_reg <= wcnt_next;
    end
  end

  // fifo sits between correction and output registers; it only fills if the sink stalls
  dpab_fifo_if #(.W(2*OUT_W)) f_in ();
  dpab_fifo_if #(.W(2*OUT_W)) f_out ();
  assign f_in.valid = (st_reg == DPAB_RUN);
  assign f_in.data = {i_cor_reg, q_cor_reg};
  dpab_fifo #(.W(2*OUT_W), .DEPTH(DPAB_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(f_in),
    .out_s(f_out)
  );

  // output register: both buses update on the same edge
  logic [OUT_W-1:0] i_out_next, q_out_next;
  logic ov_next;
  logic take;
  assign take = !out_valid || out_ready;
  assign f_out.ready = take;
  always_comb begin
    i_out_next = i_chan_out;
    q_out_next = q_chan_out;
    ov_next = out_valid;
    if (take) begin
      ov_next = f_out.valid;
      if (f_out.valid) begin
        {i_out_next, q_out_next} = f_out.data;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i_chan_out <= '0;
      q_chan_out <= '0;
      out_valid <= 1'b0;
    end else begin
      i_chan_out <= i_out_next;
      q_chan_out <= q_out_next;
      out_valid <= ov_next;
    end
  end

  // assertions
  // correction words two clocks back: the output path length while the fifo holds one pair
  logic [OUT_W-1:0] i_cor_d1, i_cor_d2, q_cor_d1, q_cor_d2;
  always_ff @(posedge clk) begin
    i_cor_d1 <= i_cor_reg;
    i_cor_d2 <= i_cor_d1;
    q_cor_d1 <= q_cor_reg;
    q_cor_d2 <= q_cor_d1;
  end

  property p_phase_nonoverlap;
    @(posedge clk) disable iff (!rst_n) !(phase1_reg_o && phase2_reg_o);
  endproperty
  a_phase_nonoverlap: assert property (p_phase_nonoverlap) else $error("phases overlap");

  // hold phase follows the track phase after one gap cycle
  property p_phase_seq;
    @(posedge clk) disable iff (!rst_n) phase1_reg_o |-> ##2 phase2_reg_o;
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("hold phase not two cycles after track");

  property p_stage_alt;
    @(posedge clk) disable iff (!rst_n) stage_clk_o[1] == !stage_clk_o[0] && stage_clk_o[2] == stage_clk_o[0];
  endproperty
  a_stage_alt: assert property (p_stage_alt) else $error("stage clocks not alternating");

  property p_no_valid_warmup;
    @(posedge clk) disable iff (!rst_n) (st_reg == DPAB_WARMUP) |=> !out_valid;
  endproperty
  a_no_valid_warmup: assert property (p_no_valid_warmup) else $error("valid during warmup");

  property p_warmup_len;
    @(posedge clk) $rose(rst_n) |-> ##20 (st_reg == DPAB_RUN);
  endproperty
  a_warmup_len: assert property (p_warmup_len) else $error("warmup not twenty cycles");

  property p_latency;
    @(posedge clk) disable iff (!rst_n)
      (take && u_fifo.cnt_reg == 4'h1 && $past(f_in.valid))
        |=> (i_chan_out == i_cor_d2 && q_chan_out == q_cor_d2);
  endproperty
  a_latency: assert property (p_latency) else $error("output not correction word delayed two");

  property p_stream;
    @(posedge clk) disable iff (!rst_n) (out_valid && out_ready && st_reg == DPAB_RUN) |=> out_valid;
  endproperty
  a_stream: assert property (p_stream) else $error("gap in output stream");

  property p_hold;
    @(posedge clk) disable iff (!rst_n) (out_valid && !out_ready) |=> $stable(i_chan_out) && $stable(q_chan_out);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs changed while stalled");

  property p_fullscale;
    @(posedge clk) (i_aligned == '1) |=> (i_cor_reg == '1);
  endproperty
  a_fullscale: assert property (p_fullscale) else $error("full scale not all ones");

  c_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(out_valid));
  c_stall: cover property (@(posedge clk) disable iff (!rst_n) out_valid && !out_ready);
  c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) !f_in.ready);
endmodule // dpab_backend

//--- verilog/dpab_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
module dpab_fifo import dpab_pkg::*; #(
  parameter int W = 20,
  parameter int DEPTH = DPAB_FIFO_DEPTH
) (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // synchronous reset, active low
  dpab_fifo_if.snk in_s, // filling side
  dpab_fifo_if.src out_s // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // honest full/empty from the occupancy count
  assign in_s.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = mem_reg[rp_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // pointer and count update
  always_comb begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_s.data;
    end
  end

  property p_no_overflow;
    @(posedge clk) disable iff (!rst_n) cnt_reg <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule // dpab_fifo

//--- verilog/dpab_fifo_if.sv
// interface carrying a valid/ready stream between back end modules
`timescale 1ns/1ps
interface dpab_fifo_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- verilog/dpab_pkg.sv
// package of constants and types for the dual pipeline adc digital back end
package dpab_pkg;
  localparam int DPAB_OUT_W = 10;
  localparam int DPAB_STAGES = 9;
  localparam int DPAB_RAW_W = 2 * DPAB_STAGES;
  localparam int DPAB_LATENCY = 6;
  localparam int DPAB_ALIGN_LAT = DPAB_LATENCY - 2;
  localparam int DPAB_INVALID_CYC = 20;
  localparam int DPAB_FIFO_DEPTH = 8;
  localparam logic [4:0] DPAB_CNT_RST = 5'h00;
  // stage clocks after reset: phase1 low, so odd stages start high
  localparam logic [8:0] DPAB_SCLK_RST = 9'h0aa;
  typedef enum logic [0:0] {DPAB_WARMUP, DPAB_RUN} dpab_state_t;
endpackage
